// file: hw/tpsc_defs.svh
`ifndef TPSC_DEFS_SVH
`define TPSC_DEFS_SVH

// synchroniser depth for pin inputs
`define TPSC_SYNC_STAGES 2
// link clock period in ns, for reference; the block itself only finds edges
`define TPSC_TCK_PERIOD_NS 400
// least tms-high tck cycles that return the tap to reset
`define TPSC_TMS_HIGH_EXIT 3'h5
// width of the tap instruction shift register
`define TPSC_IR_WIDTH 4

`endif

// file: hw/tpsc_pkg.sv
package tpsc_pkg;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } tpsc_tap_e;

endpackage : tpsc_pkg

// file: hw/tpsc_sync.sv
`timescale 1ns/1ns
`default_nettype none

module tpsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // async input and its synchronised copy
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tpsc_sync_s;

  tpsc_sync_s s_q;
  tpsc_sync_s s_d;

  // first stage feeds the second stage only
  always_comb begin
    s_d.meta   = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule : tpsc_sync

`default_nettype wire

// file: hw/tpsc_pin_share.sv
// Behaviour
// - tms is never user i/o in any mode.
// - dedicated mode: all test pins reserved, pull-ups on tms and tdi, standard tap.
// - flexible mode: tdi, tck, tdo shared with user i/o; no tms/tdi pull-ups.
// - mode is a static strap; flexible when reserve option unset.
// - tap starts in test-logic-reset; flexible pins are then user i/o.
// - flexible: rising tck with tms low hands pins to boundary scan.
// - reserved test reset: trst is only scan reset, pull-up always on.
// - trst not reserved: plain i/o, tristated output when unused.
// - reserved trst is active low; scan_reset follows it asynchronously, the tap resets through the synchroniser.
`timescale 1ns/1ns
`default_nettype none
`include "tpsc_defs.svh"

module tpsc_pin_share (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // static configuration straps
  input  wire logic reserve_test_pins,
  input  wire logic reserve_test_reset,
  // test pins seen from the board
  input  wire logic tms_pin,
  input  wire logic tck_pin,
  input  wire logic tdi_pin,
  input  wire logic trst_n_pin,
  output logic      tdo_pin_o,
  output logic      tdo_pin_oe_n,
  output logic      tck_pin_o,
  output logic      tck_pin_oe_n,
  output logic      tdi_pin_o,
  output logic      tdi_pin_oe_n,
  output logic      trst_pin_o,
  output logic      trst_pin_oe_n,
  // pull-up controls
  output logic      tms_pullup_en,
  output logic      tdi_pullup_en,
  output logic      trst_pullup_en,
  // user logic side of the shared pins
  input  wire logic user_tdo_out,
  input  wire logic user_tdo_oe,
  input  wire logic user_tck_out,
  input  wire logic user_tck_oe,
  input  wire logic user_tdi_out,
  input  wire logic user_tdi_oe,
  input  wire logic user_trst_out,
  input  wire logic user_trst_oe,
  input  wire logic user_trst_used,
  output logic      user_tck_in,
  output logic      user_tdi_in,
  output logic      user_trst_in,
  // boundary scan side
  input  wire logic scan_tdo,
  input  wire logic scan_tdo_en,
  output logic      scan_tdi,
  output logic      scan_tck_rise,
  output logic      scan_tck_fall,
  output logic      scan_reset,
  output logic      boundary_scan_function,
  output tpsc_pkg::tpsc_tap_e tap_state
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [3:0] pins_s;

  tpsc_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .async_i ({trst_n_pin, tdi_pin, tck_pin, tms_pin}),
    .sync_o  (pins_s)
  );

  logic tms_s;
  logic tck_s;
  logic tdi_s;
  logic trst_n_s;

  assign tms_s    = pins_s[0];
  assign tck_s    = pins_s[1];
  assign tdi_s    = pins_s[2];
  assign trst_n_s = pins_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    tpsc_pkg::tpsc_tap_e tap;
    logic                tck_prev;
    logic                dedicated;
    logic                trst_rsv;
    logic                straps_taken;
    logic                scan_tdi;
    logic                tdo;
    logic                tdo_en;
    logic                rise;
    logic                fall;
  } tpsc_ctl_s;

  tpsc_ctl_s c_q;
  tpsc_ctl_s c_d;

  function automatic tpsc_pkg::tpsc_tap_e tap_next(input tpsc_pkg::tpsc_tap_e st, input logic tms);
    tpsc_pkg::tpsc_tap_e nx;
    nx = st;
    unique case (st)
      tpsc_pkg::TAP_RESET:    nx = tms ? tpsc_pkg::TAP_RESET   : tpsc_pkg::TAP_IDLE;
      tpsc_pkg::TAP_IDLE:     nx = tms ? tpsc_pkg::TAP_SEL_DR  : tpsc_pkg::TAP_IDLE;
      tpsc_pkg::TAP_SEL_DR:   nx = tms ? tpsc_pkg::TAP_SEL_IR  : tpsc_pkg::TAP_CAP_DR;
      tpsc_pkg::TAP_CAP_DR:   nx = tms ? tpsc_pkg::TAP_EXIT1_DR : tpsc_pkg::TAP_SHIFT_DR;
      tpsc_pkg::TAP_SHIFT_DR: nx = tms ? tpsc_pkg::TAP_EXIT1_DR : tpsc_pkg::TAP_SHIFT_DR;
      tpsc_pkg::TAP_EXIT1_DR: nx = tms ? tpsc_pkg::TAP_UPD_DR  : tpsc_pkg::TAP_PAUSE_DR;
      tpsc_pkg::TAP_PAUSE_DR: nx = tms ? tpsc_pkg::TAP_EXIT2_DR : tpsc_pkg::TAP_PAUSE_DR;
      tpsc_pkg::TAP_EXIT2_DR: nx = tms ? tpsc_pkg::TAP_UPD_DR  : tpsc_pkg::TAP_SHIFT_DR;
      tpsc_pkg::TAP_UPD_DR:   nx = tms ? tpsc_pkg::TAP_SEL_DR  : tpsc_pkg::TAP_IDLE;
      tpsc_pkg::TAP_SEL_IR:   nx = tms ? tpsc_pkg::TAP_RESET   : tpsc_pkg::TAP_CAP_IR;
      tpsc_pkg::TAP_CAP_IR:   nx = tms ? tpsc_pkg::TAP_EXIT1_IR : tpsc_pkg::TAP_SHIFT_IR;
      tpsc_pkg::TAP_SHIFT_IR: nx = tms ? tpsc_pkg::TAP_EXIT1_IR : tpsc_pkg::TAP_SHIFT_IR;
      tpsc_pkg::TAP_EXIT1_IR: nx = tms ? tpsc_pkg::TAP_UPD_IR  : tpsc_pkg::TAP_PAUSE_IR;
      tpsc_pkg::TAP_PAUSE_IR: nx = tms ? tpsc_pkg::TAP_EXIT2_IR : tpsc_pkg::TAP_PAUSE_IR;
      tpsc_pkg::TAP_EXIT2_IR: nx = tms ? tpsc_pkg::TAP_UPD_IR  : tpsc_pkg::TAP_SHIFT_IR;
      tpsc_pkg::TAP_UPD_IR:   nx = tms ? tpsc_pkg::TAP_SEL_DR  : tpsc_pkg::TAP_IDLE;
    endcase
    return nx;
  endfunction : tap_next

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic tck_rise;
  logic tck_fall;
  logic trst_hit;

  assign tck_rise = tck_s & ~c_q.tck_prev;
  assign tck_fall = ~tck_s & c_q.tck_prev;
  // trst only acts once the reset pin is reserved; otherwise it is user i/o
  assign trst_hit = c_q.trst_rsv & ~trst_n_pin;
  // limitation: the raw pin is not filtered, so a glitch on it resets scan logic

  always_comb begin
    c_d          = c_q;
    c_d.tck_prev = tck_s;
    c_d.rise     = 1'b0;
    c_d.fall     = 1'b0;
    // straps are caught once after reset release and then held
    // a strap change mid-run is ignored so a live scan never loses its pins
    if (!c_q.straps_taken) begin
      c_d.dedicated    = reserve_test_pins;
      c_d.trst_rsv     = reserve_test_reset;
      c_d.straps_taken = 1'b1;
    end
    // tms and tck share one synchroniser, so tms is seen as it stood at the edge
    if (tck_rise) begin
      c_d.rise     = 1'b1;
      c_d.tap      = tap_next(c_q.tap, tms_s);
      c_d.scan_tdi = tdi_s;
    end
    if (tck_fall) begin
      c_d.fall   = 1'b1;
      c_d.tdo    = scan_tdo;
      c_d.tdo_en = scan_tdo_en;
    end
    if (c_q.trst_rsv && !trst_n_s) begin
      c_d.tap = tpsc_pkg::TAP_RESET;
    end
  end

  // trst resets the tap synchronously, through the synchronised pin; only scan_reset follows the raw pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_q     <= '0;
      c_q.tap <= tpsc_pkg::TAP_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership

  logic scan_owns;

  // dedicated owns always; flexible owns outside test-logic-reset
  assign scan_owns = c_q.dedicated | (c_q.tap != tpsc_pkg::TAP_RESET);

  assign boundary_scan_function = scan_owns;
  assign tap_state              = c_q.tap;
  assign scan_tdi               = c_q.scan_tdi;
  assign scan_tck_rise          = c_q.rise;
  assign scan_tck_fall          = c_q.fall;
  assign scan_reset             = (c_q.tap == tpsc_pkg::TAP_RESET) | trst_hit;

  // tms has no user path at all
  assign tms_pullup_en = c_q.dedicated;
  assign tdi_pullup_en = c_q.dedicated;
  assign trst_pullup_en = c_q.trst_rsv;

  // user inputs read zero while scan owns the pin
  // reading zero rather than the pin keeps user logic from reacting to test traffic
  assign user_tck_in  = scan_owns ? 1'b0 : tck_s;
  assign user_tdi_in  = scan_owns ? 1'b0 : tdi_s;
  assign user_trst_in = c_q.trst_rsv ? 1'b0 : trst_n_s;

  // tdo driven only by scan when owned, tck and tdi are inputs to scan
  assign tdo_pin_o    = scan_owns ? c_q.tdo : user_tdo_out;
  assign tdo_pin_oe_n = scan_owns ? ~c_q.tdo_en : ~user_tdo_oe;
  assign tck_pin_o    = user_tck_out;
  assign tck_pin_oe_n = scan_owns | ~user_tck_oe;
  assign tdi_pin_o    = user_tdi_out;
  assign tdi_pin_oe_n = scan_owns | ~user_tdi_oe;

  // an unused trst i/o is left tristated
  assign trst_pin_o    = user_trst_out;
  assign trst_pin_oe_n = c_q.trst_rsv | ~user_trst_used | ~user_trst_oe;

endmodule : tpsc_pin_share

`default_nettype wire

// file: tb/tpsc_tester.sv
`timescale 1ns/1ns
`default_nettype none
module tpsc_tester (
  // test pins toward the device
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tck stands low between bits; 400 ns period
  task automatic bit_out(input logic m);
    tms = m;
    tdi = ~tdi;
    #200 tck = 1'b1;
    #200 tck = 1'b0;
  endtask : bit_out
endmodule : tpsc_tester
`default_nettype wire

// file: tb/tpsc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tpsc_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins and controls
  input wire logic trst_n_pin,
  input wire logic tdo_pin_oe_n,
  input wire logic tck_pin_oe_n,
  input wire logic tdi_pin_oe_n,
  input wire logic trst_pin_oe_n,
  input wire logic tms_pullup_en,
  input wire logic tdi_pullup_en,
  input wire logic trst_pullup_en,
  input wire logic user_tdo_oe,
  input wire logic user_trst_used,
  input wire logic user_tck_in,
  input wire logic user_trst_in,
  input wire logic scan_tck_rise,
  input wire logic scan_reset,
  input wire logic boundary_scan_function,
  input wire tpsc_pkg::tpsc_tap_e tap_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ded; tms_pullup_en |-> tdi_pullup_en && tck_pin_oe_n && tdi_pin_oe_n; endproperty
  a_ded: assert property (p_ded) else $error("dedicated pins not reserved");
  property p_user; tap_state == tpsc_pkg::TAP_RESET && !tms_pullup_en |-> !boundary_scan_function
    && tdo_pin_oe_n == !user_tdo_oe; endproperty
  a_user: assert property (p_user) else $error("reset state not user io");
  property p_enter; $past(tap_state) == tpsc_pkg::TAP_RESET && tap_state == tpsc_pkg::TAP_IDLE
    |-> boundary_scan_function && scan_tck_rise; endproperty
  a_enter: assert property (p_enter) else $error("scan entry wrong");
  property p_own; boundary_scan_function |-> tck_pin_oe_n && tdi_pin_oe_n && !user_tck_in; endproperty
  a_own: assert property (p_own) else $error("shared pin driven by user");
  property p_step; $changed(tap_state) && tap_state != tpsc_pkg::TAP_RESET |-> scan_tck_rise; endproperty
  a_step: assert property (p_step) else $error("tap moved without tck");
  property p_trst; trst_pullup_en |-> trst_pin_oe_n && !user_trst_in; endproperty
  a_trst: assert property (p_trst) else $error("reserved trst used as io");
  property p_trio; !trst_pullup_en && !user_trst_used |-> trst_pin_oe_n; endproperty
  a_trio: assert property (p_trio) else $error("unused trst driven");
  property p_arst; (trst_pullup_en && !trst_n_pin)[*4] |-> scan_reset ##1 tap_state == tpsc_pkg::TAP_RESET;
  endproperty
  a_arst: assert property (p_arst) else $error("trst low did not reset");
  c_own: cover property (boundary_scan_function);
  c_shift: cover property (tap_state == tpsc_pkg::TAP_SHIFT_DR);
  c_trst: cover property (trst_pullup_en && !trst_n_pin);
endmodule : tpsc_chk
bind tpsc_pin_share tpsc_chk u_chk (.*);
`default_nettype wire

// file: tb/tpsc_pin_share_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tpsc_pin_share_tb;
  logic mclk, rst_n, reserve_test_pins, reserve_test_reset, trst_n_pin, tms_pin, tck_pin, tdi_pin;
  logic tdo_pin_o, tdo_pin_oe_n, tck_pin_o, tck_pin_oe_n, tdi_pin_o, tdi_pin_oe_n, trst_pin_o, trst_pin_oe_n;
  logic tms_pullup_en, tdi_pullup_en, trst_pullup_en, user_tck_in, user_tdi_in, user_trst_in;
  logic user_tdo_out, user_tdo_oe, user_tck_out, user_tck_oe, user_tdi_out, user_tdi_oe;
  logic user_trst_out, user_trst_oe, user_trst_used, scan_tdo, scan_tdo_en;
  logic scan_tdi, scan_tck_rise, scan_tck_fall, scan_reset, boundary_scan_function;
  tpsc_pkg::tpsc_tap_e tap_state;
  int error_cnt;
  int comparisons;
  tpsc_pin_share dut (.*);
  tpsc_tester u_tst (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk_b(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask : chk_b
  task automatic chk_s(input tpsc_pkg::tpsc_tap_e e);
    comparisons++;
    if (tap_state !== e) begin
      error_cnt++;
      $display("ERROR tap_state exp %h got %h", e, tap_state);
    end
  endtask : chk_s
  // straps are caught only after a reset, so each mode gets its own
  task automatic start(input logic pins, input logic trst);
    @(posedge mclk) #2 rst_n = 1'b0;
    reserve_test_pins = pins;
    reserve_test_reset = trst;
    repeat (12) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
  endtask : start
  //////////////////////////////////////////////////////////////////////////
  task automatic t_ded();
    start(1'b1, 1'b1);
    chk_b("tms_pu", 1'b1, tms_pullup_en);
    chk_b("tdi_pu", 1'b1, tdi_pullup_en);
    chk_b("trst_pu", 1'b1, trst_pullup_en);
    chk_b("trst_oe_n", 1'b1, trst_pin_oe_n);
    chk_b("bsf", 1'b1, boundary_scan_function);
    chk_b("tdo_oe_n", 1'b1, tdo_pin_oe_n);
    u_tst.bit_out(1'b0);
    chk_s(tpsc_pkg::TAP_IDLE);
    @(posedge mclk) #2 trst_n_pin = 1'b0;
    #1 chk_b("scan_reset", 1'b1, scan_reset);
    repeat (6) @(posedge mclk);
    #2 chk_s(tpsc_pkg::TAP_RESET);
    trst_n_pin = 1'b1;
  endtask : t_ded
  task automatic t_flex();
    start(1'b0, 1'b0);
    chk_b("tms_pu", 1'b0, tms_pullup_en);
    chk_b("bsf", 1'b0, boundary_scan_function);
    chk_b("tdo_oe_n", 1'b0, tdo_pin_oe_n);
    chk_b("trst_oe_n", 1'b0, trst_pin_oe_n);
    user_trst_used = 1'b0;
    reserve_test_pins = 1'b1;
    #1 chk_b("trst_oe_n", 1'b1, trst_pin_oe_n);
    u_tst.bit_out(1'b0);
    repeat (3) @(posedge mclk);
    #2 chk_b("scan_tck_fall", 1'b1, scan_tck_fall);
    #200 chk_s(tpsc_pkg::TAP_IDLE);
    chk_b("bsf", 1'b1, boundary_scan_function);
    chk_b("tdo_oe_n", 1'b0, tdo_pin_oe_n);
    scan_tdo_en = 1'b0;
    scan_tdo = 1'b0;
    u_tst.bit_out(1'b1);
    u_tst.bit_out(1'b0);
    u_tst.bit_out(1'b0);
    #200 chk_s(tpsc_pkg::TAP_SHIFT_DR);
    chk_b("tdo_oe_n", 1'b1, tdo_pin_oe_n);
    chk_b("tdo_o", 1'b0, tdo_pin_o);
    chk_b("scan_tdi", tdi_pin, scan_tdi);
    chk_b("user_tdi_in", 1'b0, user_tdi_in);
    chk_b("tms_pu", 1'b0, tms_pullup_en);
    repeat (4) u_tst.bit_out(1'b1);
    chk_s(tpsc_pkg::TAP_SEL_IR);
    u_tst.bit_out(1'b1);
    chk_s(tpsc_pkg::TAP_RESET);
    chk_b("bsf", 1'b0, boundary_scan_function);
    user_tdo_out = 1'b0;
    user_tck_out = 1'b1;
    user_tdi_out = 1'b1;
    user_trst_out = 1'b0;
    user_trst_used = 1'b1;
    #1 chk_b("tdo_o", 1'b0, tdo_pin_o);
    chk_b("tck_o", 1'b1, tck_pin_o);
    chk_b("tdi_o", 1'b1, tdi_pin_o);
    chk_b("trst_o", 1'b0, trst_pin_o);
    chk_b("trst_oe_n", 1'b0, trst_pin_oe_n);
    chk_b("tck_oe_n", 1'b0, tck_pin_oe_n);
    chk_b("user_tdi_in", tdi_pin, user_tdi_in);
    chk_b("user_trst_in", 1'b1, user_trst_in);
    user_tck_oe = 1'b0;
    user_tdi_oe = 1'b0;
    #1 chk_b("tck_oe_n", 1'b1, tck_pin_oe_n);
    chk_b("tdi_oe_n", 1'b1, tdi_pin_oe_n);
  endtask : t_flex
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    {rst_n, reserve_test_pins, reserve_test_reset, trst_n_pin} = 4'h1;
    {user_tdo_out, user_tdo_oe, user_tck_out, user_tck_oe, user_tdi_out, user_tdi_oe} = 6'h35;
    {user_trst_out, user_trst_oe, user_trst_used, scan_tdo, scan_tdo_en} = 5'h1f;
    t_ded();
    t_flex();
    test_done();
  end
endmodule : tpsc_pin_share_tb
`default_nettype wire
